/* File: overclock_freq_watchdog_control.sv */
// overclock frequency selection, smooth switch routing and watchdog
// assumes register fields arrive from the serial register port on clk_sys
`timescale 1ns/1ps
module overclock_freq_watchdog_control
	import ocwd_pkg::*;
#(
	parameter int unsigned PULSE_CYCLES = PULSE_CYC,
	parameter int unsigned TICK_CYCLES  = TICK_CYC
)(
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic [1:0] platformStrap,
	input  wire logic [4:0] freqStrapPins,
	input  wire logic       system_reset_strap,
	input  wire logic       power_good_in_n,
	input  wire logic [1:0] dynamic_freq_pins,
	input  wire logic       dynamic_freq_enable,
	input  wire logic [8:0] dynamic_n_set_one,
	input  wire logic [8:0] dynamic_n_set_two,
	input  wire logic [8:0] dynamic_n_set_three,
	input  wire logic       cpu_prog_freq_enable,
	input  wire nm_s        cpuProg,
	input  wire logic       src_prog_freq_enable,
	input  wire logic [8:0] src_prog_n_value,
	input  wire logic [3:0] soft_table_select,
	input  wire logic       strap_override,
	input  wire logic       smoothManual,
	input  wire logic       smoothToSrc,
	input  wire logic [8:0] recoveryNWrite,
	input  wire logic       recoveryNWe,
	input  wire wd_ctrl_s   wdCtrl,
	output pin_fn_e         linkDotSataFn,
	output pin_fn_e         sataPcieFn,
	output logic [4:0]      latched_strap_select,
	output logic [3:0]      cpuTableIndex,
	output freq_src_e       cpuFreqSource,
	output nm_s             cpuNm,
	output logic            srcProgActive,
	output logic [8:0]      srcN,
	output logic            smoothOnSrc,
	output logic [8:0]      watchdog_recovery_n_value,
	output logic            watchdogAlarm,
	output logic            system_reset_out_n,
	output logic            system_reset_out_oe_n
);
	typedef enum logic [1:0] {WD_IDLE, WD_COUNT, WD_PULSE, WD_DONE} wd_e;

	// input synchronisers for pins
	logic [1:0] dfMeta, dfSync, selMeta, selSync;
	logic [4:0] fsMeta, fsSync;
	logic       pgMeta, pgSync, srMeta, srSync;
	always_ff @(posedge clk_sys) begin
		dfMeta  <= dynamic_freq_pins;
		dfSync  <= dfMeta;
		selMeta <= platformStrap;
		selSync <= selMeta;
		fsMeta  <= freqStrapPins;
		fsSync  <= fsMeta;
		pgMeta  <= power_good_in_n;
		pgSync  <= pgMeta;
		srMeta  <= system_reset_strap;
		srSync  <= srMeta;
	end

	// boot strap capture on first power-good assertion
	logic bootDone_reg, resetOutEn_reg;
	logic [4:0] strapFs_reg;
	logic [1:0] strapSel_reg;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bootDone_reg   <= 1'b0;
			resetOutEn_reg <= 1'b0;
			strapFs_reg    <= 5'h00;
			strapSel_reg   <= 2'h0;
		end else if (!bootDone_reg && !pgSync) begin
			bootDone_reg   <= 1'b1;
			resetOutEn_reg <= !srSync;
			strapFs_reg    <= fsSync;
			strapSel_reg   <= selSync;
		end
	end
	assign latched_strap_select = strapFs_reg;

	// multifunction pin map
	assign linkDotSataFn = (strapSel_reg == 2'h1) ? PIN_DOT :
		(strapSel_reg == 2'h3) ? PIN_SATA : PIN_LINK;
	assign sataPcieFn = strapSel_reg[1] ? PIN_PCIE : PIN_SATA;

	// watchdog control edges
	logic wdEnPrev_reg;
	wire  enRise = wdCtrl.wdEnable && !wdEnPrev_reg;

	// recovery registers
	logic [6:0] recM_reg;
	logic [8:0] recN_reg;
	logic       fromTable_reg; // set when soft select was active at arming
	logic       restore; // expiry pulse that reloads frequency
	logic       restoreActive_reg;
	nm_s        restoreNm_reg;
	freq_src_e  restoreSrc_reg;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			recM_reg      <= M_RST;
			recN_reg      <= N_RST;
			fromTable_reg <= 1'b0;
		end else begin
			if (enRise) begin
				recM_reg      <= cpuNm.m;
				fromTable_reg <= strap_override;
			end
			if (enRise && wdCtrl.wdAutoRecovery)
				recN_reg <= cpuNm.n;
			else if (recoveryNWe && !wdCtrl.wdAutoRecovery)
				recN_reg <= recoveryNWrite;
		end
	end
	assign watchdog_recovery_n_value = recN_reg;

	// restore latch, cleared on a watchdog enable rise or while software has every source control off
	wire srcTouched = cpu_prog_freq_enable == 1'b0 && strap_override == 1'b0
		&& dynamic_freq_enable == 1'b0;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			restoreActive_reg <= 1'b0;
			restoreNm_reg     <= '0;
			restoreSrc_reg    <= SRC_STRAP;
		end else if (restore) begin
			restoreActive_reg <= 1'b1;
			if (fromTable_reg || !wdCtrl.wdRecoveryMode) begin
				restoreSrc_reg <= SRC_STRAP;
			end else begin
				restoreSrc_reg <= SRC_PROG;
				restoreNm_reg  <= '{n: recN_reg, m: recM_reg};
			end
		end else if (enRise || srcTouched) begin
			restoreActive_reg <= 1'b0;
		end
	end

	// cpu frequency source selection
	wire [8:0] dynN = (dfSync == 2'h1) ? dynamic_n_set_one :
		(dfSync == 2'h2) ? dynamic_n_set_two : dynamic_n_set_three;
	wire dynActive = dynamic_freq_enable && (dfSync != 2'h0);
	assign cpuTableIndex = strap_override ? soft_table_select
		: {1'b0, strapFs_reg[2:0]};
	always_comb begin
		cpuFreqSource = strap_override ? SRC_TABLE : SRC_STRAP;
		cpuNm = cpuProg;
		if (restoreActive_reg) begin
			cpuFreqSource = restoreSrc_reg;
			cpuNm = restoreNm_reg;
		end else if (dynActive) begin
			cpuFreqSource = SRC_DYN;
			cpuNm.n = dynN;
		end else if (cpu_prog_freq_enable) begin
			cpuFreqSource = SRC_PROG;
		end
	end
	// src pll: only N, M fixed by gear; no recovery
	assign srcProgActive = src_prog_freq_enable;
	assign srcN = src_prog_n_value;

	// smooth switch follows the PLL being overclocked, or smoothToSrc while smoothManual is set
	wire cpuOc = cpuFreqSource != SRC_STRAP;
	assign smoothOnSrc = smoothManual ? smoothToSrc
		: (src_prog_freq_enable && !cpuOc);

	// watchdog: ms tick and counters
	wd_e         wdState_reg, wdState_next;
	logic [31:0] tickCnt_reg, msLeft_reg, pulseCnt_reg;
	logic        alarm_reg;
	wire         tick = tickCnt_reg == TICK_CYCLES - 1;
	wire [31:0]  scaleMs = wdCtrl.wdScale ? SCALE_HI_MS : SCALE_LO_MS;
	wire [31:0]  loadMs = 32'(wdCtrl.wdTimer) * scaleMs;
	wire         reload = enRise || (wdCtrl.timerWrite && wdCtrl.wdEnable);
	// expiry only while enabled; a reload in the same cycle wins
	wire         expire = wdState_reg == WD_COUNT && wdCtrl.wdEnable
		&& !reload && tick && msLeft_reg <= 1;
	assign restore = expire && !wdCtrl.wdResetMode;

	always_comb begin
		wdState_next = wdState_reg;
		unique case (wdState_reg)
			WD_IDLE:  if (reload) wdState_next = WD_COUNT;
			WD_COUNT: if (!wdCtrl.wdEnable) wdState_next = WD_IDLE;
				else if (reload) wdState_next = WD_COUNT;
				else if (expire) wdState_next = WD_PULSE;
			WD_PULSE: if (pulseCnt_reg == PULSE_CYCLES - 1)
					wdState_next = WD_DONE;
			WD_DONE:  if (reload) wdState_next = WD_COUNT;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wdState_reg  <= WD_IDLE;
			wdEnPrev_reg <= 1'b0;
			tickCnt_reg  <= '0;
			msLeft_reg   <= '0;
			pulseCnt_reg <= '0;
		end else begin
			wdState_reg  <= wdState_next;
			wdEnPrev_reg <= wdCtrl.wdEnable;
			tickCnt_reg  <= (tick || reload) ? '0 : tickCnt_reg + 1;
			if (reload)
				msLeft_reg <= loadMs;
			else if (tick && msLeft_reg != 0)
				msLeft_reg <= msLeft_reg - 1;
			pulseCnt_reg <= (wdState_reg == WD_PULSE)
				? pulseCnt_reg + 1 : '0;
		end
	end

	// alarm flag: expiry wins over a clear
	always_ff @(posedge clk_sys) begin
		if (rst)
			alarm_reg <= 1'b0;
		else if (expire)
			alarm_reg <= 1'b1;
		else if (wdCtrl.alarmClear)
			alarm_reg <= 1'b0;
	end
	assign watchdogAlarm = alarm_reg;

	// open-drain style reset output, low only while pulsing
	logic resetOut_reg;
	always_ff @(posedge clk_sys) begin
		if (rst)
			resetOut_reg <= 1'b0;
		else
			resetOut_reg <= wdState_next == WD_PULSE && resetOutEn_reg;
	end
	assign system_reset_out_n    = !resetOut_reg;
	assign system_reset_out_oe_n = !resetOut_reg;

	// checks
	alarm_on_expiry_a: assert property (@(posedge clk_sys) disable iff (rst)
		expire |=> watchdogAlarm) else $error("alarm not set");
	pulse_start_a: assert property (@(posedge clk_sys) disable iff (rst)
		expire && resetOutEn_reg |=> !system_reset_out_n)
		else $error("reset pulse missing");
	no_reset_dis_a: assert property (@(posedge clk_sys) disable iff (rst)
		!resetOutEn_reg |-> system_reset_out_n)
		else $error("reset while disabled");
	reload_count_a: assert property (@(posedge clk_sys) disable iff (rst)
		reload |=> msLeft_reg == $past(loadMs))
		else $error("reload missed");
	done_stays_a: assert property (@(posedge clk_sys) disable iff (rst)
		wdState_reg == WD_DONE && !reload |=> wdState_reg == WD_DONE)
		else $error("rearmed itself");
	pin_map_a: assert property (@(posedge clk_sys) disable iff (rst)
		strapSel_reg == 2'h3 |-> linkDotSataFn == PIN_SATA
		&& sataPcieFn == PIN_PCIE) else $error("pin map");
	strap_sel_a: assert property (@(posedge clk_sys) disable iff (rst)
		!restoreActive_reg && !dynActive && !cpu_prog_freq_enable
		|-> cpuFreqSource == (strap_override ? SRC_TABLE : SRC_STRAP))
		else $error("source select");
	dyn_pick_a: assert property (@(posedge clk_sys) disable iff (rst)
		!restoreActive_reg && dynActive && dfSync == 2'h2
		|-> cpuNm.n == dynamic_n_set_two) else $error("dyn n");
	latch_rec_a: assert property (@(posedge clk_sys) disable iff (rst)
		enRise |=> recM_reg == $past(cpuNm.m))
		else $error("recovery m latch");

	// rearm steps: a reload outside the pulse lands in the count state
	sequence armEdge;
		reload && wdState_reg != WD_PULSE;
	endsequence
	sequence countingNow;
		wdState_reg == WD_COUNT;
	endsequence
	arm_count_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		armEdge |=> countingNow) else $error("reload did not arm");
	alarm_clear_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		wdCtrl.alarmClear && !expire |=> !watchdogAlarm)
		else $error("alarm clear ignored");
	hw_restore_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		restore && (fromTable_reg || !wdCtrl.wdRecoveryMode)
		|=> restoreActive_reg && restoreSrc_reg == SRC_STRAP)
		else $error("hardware restore missed");
	no_recover_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		expire && wdCtrl.wdResetMode && !restoreActive_reg
		|=> !restoreActive_reg)
		else $error("restored in reset-only mode");
	rec_refused_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		recoveryNWe && wdCtrl.wdAutoRecovery && !enRise
		|=> $stable(recN_reg))
		else $error("recovery write taken in auto mode");
	pulse_bound_a: assert property (
		@(posedge clk_sys) disable iff (rst)
		wdState_reg == WD_PULSE |-> pulseCnt_reg < PULSE_CYCLES)
		else $error("reset pulse too long");
endmodule : overclock_freq_watchdog_control

/* File: ocwd_pkg.sv */
// package for the overclock, frequency select and watchdog control block
// assumes a single 250 MHz system clock
package ocwd_pkg;
	localparam int unsigned CLK_MHZ      = 250;
	localparam int unsigned PULSE_MS     = 20;
	localparam int unsigned SCALE_LO_MS  = 250;
	localparam int unsigned SCALE_HI_MS  = 3000;
	localparam int unsigned PULSE_CYC    = PULSE_MS * 1000 * CLK_MHZ;
	localparam int unsigned TICK_CYC     = 1000 * CLK_MHZ; // one ms tick
	localparam logic [2:0]  WD_TIMER_RST = 3'h0;
	localparam logic        WD_SCALE_RST = 1'h1;
	localparam logic        AUTOREC_RST  = 1'h1;
	localparam logic [8:0]  N_RST        = 9'h000;
	localparam logic [6:0]  M_RST        = 7'h00;

	// multifunction pin assignment
	typedef enum logic [1:0] {PIN_LINK, PIN_DOT, PIN_SATA, PIN_PCIE} pin_fn_e;
	// where the cpu frequency comes from
	typedef enum logic [1:0] {SRC_STRAP, SRC_TABLE, SRC_PROG, SRC_DYN} freq_src_e;

	typedef struct packed {
		logic [8:0] n;
		logic [6:0] m;
	} nm_s;

	typedef struct packed {
		logic       wdEnable;
		logic [2:0] wdTimer;
		logic       wdScale;
		logic       wdResetMode;
		logic       wdRecoveryMode;
		logic       wdAutoRecovery;
		logic       alarmClear;  // one-cycle strobe
		logic       timerWrite;  // one-cycle strobe on timer or scale write
	} wd_ctrl_s;
endpackage : ocwd_pkg

/* File: host_model.sv */
// host side of the reset line: measures each system reset pulse
// assumes the wire level is resolved by the bench (pull-up when released)
`timescale 1ns/1ps
module host_model (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic sysResetWire,
	output int        pulseWidth,
	output int        pulseCount
);
	int run;
	// count low cycles, latch the width when the line returns high
	always @(posedge clk_sys) begin
		if (rst) begin
			run <= 0;
			pulseWidth <= 0;
			pulseCount <= 0;
		end else if (!sysResetWire) begin
			run <= run + 1;
		end else if (run != 0) begin
			pulseWidth <= run;
			pulseCount <= pulseCount + 1;
			run <= 0;
		end
	end
endmodule : host_model

/* File: testbench.sv */
// self-checking bench for the frequency select and watchdog block
// assumes shortened counts: 4 cycles per ms tick, 20-cycle pulse
`timescale 1ns/1ps
module testbench;
	import ocwd_pkg::*;
	logic      clk_sys = 0, rst = 1, rstStrap = 0, pgN = 1;
	logic      cpuEn = 0, dynEn = 0, srcEn = 0, ovr = 0, recWe = 0;
	logic [1:0] pStrap = 0, dynPins = 0;
	logic [3:0] tbl = 4'h5;
	logic [8:0] recN = 9'h000;
	nm_s       prog = '{9'h123, 7'h45};
	wd_ctrl_s  wd = '0;
	pin_fn_e   fnA, fnB;
	freq_src_e cpuSrc;
	nm_s       cpuNm;
	logic [3:0] tIdx;
	logic      alarm, outN, oeN;
	logic      smMan = 0, smTo = 0, srcAct, smooth;
	logic [4:0] fsPins = 5'h0A, latched;
	logic [8:0] srcNv = 9'h0F0, srcNo, recOut;
	wire       sysWire = oeN ? 1'b1 : outN;
	int        pw, pc, num_errors = 0, check_count = 0;
	always #2 clk_sys = ~clk_sys;
	overclock_freq_watchdog_control #(.PULSE_CYCLES(20),
		.TICK_CYCLES(4)) dut (.clk_sys(clk_sys), .rst(rst),
		.platformStrap(pStrap), .freqStrapPins(fsPins),
		.system_reset_strap(rstStrap), .power_good_in_n(pgN),
		.dynamic_freq_pins(dynPins), .dynamic_freq_enable(dynEn),
		.dynamic_n_set_one(9'h011), .dynamic_n_set_two(9'h022),
		.dynamic_n_set_three(9'h033), .cpu_prog_freq_enable(cpuEn),
		.cpuProg(prog), .src_prog_freq_enable(srcEn),
		.src_prog_n_value(srcNv), .soft_table_select(tbl),
		.strap_override(ovr), .smoothManual(smMan),
		.smoothToSrc(smTo), .recoveryNWrite(recN),
		.recoveryNWe(recWe), .wdCtrl(wd), .linkDotSataFn(fnA),
		.sataPcieFn(fnB), .latched_strap_select(latched),
		.cpuTableIndex(tIdx), .cpuFreqSource(cpuSrc),
		.cpuNm(cpuNm), .srcProgActive(srcAct), .srcN(srcNo),
		.smoothOnSrc(smooth), .watchdog_recovery_n_value(recOut),
		.watchdogAlarm(alarm),
		.system_reset_out_n(outN), .system_reset_out_oe_n(oeN));
	host_model partner (.clk_sys(clk_sys), .rst(rst),
		.sysResetWire(sysWire), .pulseWidth(pw), .pulseCount(pc));

	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask : chk

	task automatic cyc(int n);
		repeat (n) @(negedge clk_sys);
	endtask : cyc

	// reset, then assert power good so the straps latch
	task automatic boot(logic [1:0] s, logic r);
		@(negedge clk_sys);
		rst = 1; pgN = 1; pStrap = s; rstStrap = r; wd = '0;
		cyc(10);
		rst = 0;
		cyc(2);
		pgN = 0;
		cyc(6);
	endtask : boot

	task automatic test_pins;
		pin_fn_e ea[4] = '{PIN_LINK, PIN_DOT, PIN_LINK, PIN_SATA};
		pin_fn_e eb[4] = '{PIN_SATA, PIN_SATA, PIN_PCIE, PIN_PCIE};
		logic [4:0] fv[4] = '{5'h15, 5'h03, 5'h1C, 5'h0A};
		for (int i = 0; i < 4; i++) begin
			fsPins = fv[i];
			boot(i[1:0], 0);
			chk("pinA", 16'(ea[i]), 16'(fnA));
			chk("pinB", 16'(eb[i]), 16'(fnB));
			chk("fsLatch", 16'(fv[i]), 16'(latched));
			fsPins = ~fv[i];
			cyc(4);
			chk("fsHold", 16'(fv[i]), 16'(latched));
		end
		$display("test_pins done");
	endtask : test_pins

	task automatic test_select;
		chk("srcHw", 16'(SRC_STRAP), 16'(cpuSrc));
		chk("tblHw", 16'h2, 16'(tIdx));
		ovr = 1;
		cyc(2);
		chk("srcTbl", 16'(SRC_TABLE), 16'(cpuSrc));
		chk("tblIdx", 16'h5, 16'(tIdx));
		ovr = 0; cpuEn = 1;
		cyc(2);
		chk("srcProg", 16'(SRC_PROG), 16'(cpuSrc));
		chk("nm", 16'(prog), 16'(cpuNm));
		cpuEn = 0;
		cyc(2);
		$display("test_select done");
	endtask : test_select

	// timer 1 at 250 ms scale expires after 1000 cycles
	task automatic test_watchdog;
		int n = 0;
		wd.wdTimer = 3'h1; wd.wdResetMode = 1; wd.wdEnable = 1;
		cyc(900);
		chk("early", 16'h1, 16'(outN));
		while (outN !== 1'b0 && n < 200) begin
			cyc(1);
			n++;
		end
		chk("fired", 16'h0, 16'(outN));
		// 1 ms x 250 x 4 cycles from the load edge, 900 already waited
		chk("expiryCyc", 16'd101, 16'(n));
		chk("oeLow", 16'h0, 16'(oeN));
		chk("alarm", 16'h1, 16'(alarm));
		cyc(30);
		chk("width", 16'd20, 16'(pw));
		cyc(1200);
		chk("idle", 16'd1, 16'(pc));
		wd.alarmClear = 1;
		cyc(1);
		wd.alarmClear = 0;
		cyc(1);
		chk("clear", 16'h0, 16'(alarm));
		wd.timerWrite = 1;
		cyc(1);
		wd.timerWrite = 0;
		cyc(1230);
		chk("rearm", 16'd2, 16'(pc));
		wd.wdEnable = 0;
		$display("test_watchdog done");
	endtask : test_watchdog

	// dynamic pins pick an N set once enabled; 00 keeps the base source
	task automatic test_dynamic;
		logic [8:0] dn[4] = '{9'h000, 9'h011, 9'h022, 9'h033};
		dynPins = 2'h3;
		cyc(3);
		chk("dynDis", 16'(SRC_STRAP), 16'(cpuSrc));
		dynEn = 1;
		for (int i = 1; i < 4; i++) begin
			dynPins = i[1:0];
			cyc(3);
			chk("dynSrc", 16'(SRC_DYN), 16'(cpuSrc));
			chk("dynN", 16'(dn[i]), 16'(cpuNm.n));
		end
		dynPins = 2'h0;
		cyc(3);
		chk("dynOff", 16'(SRC_STRAP), 16'(cpuSrc));
		dynEn = 0;
		$display("test_dynamic done");
	endtask : test_dynamic

	// src programmable path and smooth switch routing, auto and manual
	task automatic test_src_smooth;
		srcEn = 1;
		cyc(1);
		chk("srcAct", 16'h1, 16'(srcAct));
		chk("srcN", 16'h00F0, 16'(srcNo));
		chk("smAuto", 16'h1, 16'(smooth));
		srcNv = 9'h1A5;
		cpuEn = 1;
		cyc(1);
		chk("srcN2", 16'h01A5, 16'(srcNo));
		chk("smCpu", 16'h0, 16'(smooth));
		smMan = 1;
		smTo = 1;
		cyc(1);
		chk("smManSrc", 16'h1, 16'(smooth));
		smTo = 0;
		cpuEn = 0;
		cyc(1);
		chk("smManCpu", 16'h0, 16'(smooth));
		smMan = 0;
		srcEn = 0;
		cyc(1);
		chk("srcOff", 16'h0, 16'(srcAct));
		$display("test_src_smooth done");
	endtask : test_src_smooth

	// clear the alarm and give the enable a fresh rising edge
	task automatic arm_wd;
		wd.alarmClear = 1;
		wd.wdEnable = 0;
		cyc(1);
		wd.alarmClear = 0;
		wd.wdEnable = 1;
		cyc(1);
	endtask : arm_wd

	// wait a bounded time for the alarm, report the cycles it took
	task automatic wait_alarm(input int lim, output int n);
		n = 0;
		while (alarm !== 1'b1 && n < lim) begin
			cyc(1);
			n++;
		end
		chk("alarmSet", 16'h1, 16'(alarm));
	endtask : wait_alarm

	// a timer write mid-count restarts the countdown from the new value
	task automatic test_restart;
		int n;
		wd.wdTimer = 3'h1;
		wd.wdResetMode = 1;
		arm_wd();
		cyc(500);
		wd.wdTimer = 3'h2;
		wd.timerWrite = 1;
		cyc(1);
		wd.timerWrite = 0;
		cyc(1000);
		chk("restarted", 16'h0, 16'(alarm));
		wait_alarm(1100, n);
		// 2 x 250 ms x 4 cycles from the write, 1000 already waited
		chk("restartCyc", 16'd1000, 16'(n));
		cyc(30);
		$display("test_restart done");
	endtask : test_restart

	// every recovery path, using the fast timer code 0 that fires on the first ms tick
	task automatic test_recovery;
		int n;
		cpuEn = 1;
		prog = '{9'h123, 7'h45};
		wd.wdTimer = 3'h0;
		wd.wdResetMode = 0;
		wd.wdRecoveryMode = 1;
		wd.wdAutoRecovery = 1;
		arm_wd();
		prog = '{9'h1AB, 7'h33};
		wait_alarm(40, n);
		chk("autoSrc", 16'(SRC_PROG), 16'(cpuSrc));
		chk("autoNm", 16'({9'h123, 7'h45}), 16'(cpuNm));
		chk("autoRecN", 16'h0123, 16'(recOut));
		cyc(30);
		recN = 9'h0AA;
		recWe = 1;
		cyc(1);
		recWe = 0;
		chk("recAuto", 16'h0123, 16'(recOut));
		wd.wdAutoRecovery = 0;
		recWe = 1;
		cyc(1);
		recWe = 0;
		chk("recManual", 16'h00AA, 16'(recOut));
		cpuEn = 0;
		cyc(1);
		cpuEn = 1;
		arm_wd();
		wait_alarm(40, n);
		chk("manNm", 16'({9'h0AA, 7'h33}), 16'(cpuNm));
		cyc(30);
		wd.wdRecoveryMode = 0;
		arm_wd();
		wait_alarm(40, n);
		chk("hwSrc", 16'(SRC_STRAP), 16'(cpuSrc));
		cyc(30);
		wd.wdRecoveryMode = 1;
		cpuEn = 0;
		ovr = 1;
		arm_wd();
		wait_alarm(40, n);
		chk("tblRec", 16'(SRC_STRAP), 16'(cpuSrc));
		cyc(30);
		ovr = 0;
		cpuEn = 1;
		wd.wdResetMode = 1;
		arm_wd();
		prog = '{9'h0C3, 7'h21};
		wait_alarm(40, n);
		chk("noRecSrc", 16'(SRC_PROG), 16'(cpuSrc));
		chk("noRecNm", 16'(prog), 16'(cpuNm));
		cyc(30);
		wd.wdEnable = 0;
		cpuEn = 0;
		$display("test_recovery done");
	endtask : test_recovery

	task automatic test_strap_high;
		boot(2'b00, 1);
		wd.wdTimer = 3'h1; wd.wdResetMode = 1; wd.wdEnable = 1;
		cyc(1200);
		chk("alarmH", 16'h1, 16'(alarm));
		chk("noPulse", 16'd0, 16'(pc));
		$display("test_strap_high done");
	endtask : test_strap_high

	task automatic summarize;
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : summarize

	initial begin
		test_pins();
		test_select();
		test_dynamic();
		test_src_smooth();
		test_watchdog();
		test_restart();
		test_recovery();
		test_strap_high();
		summarize();
	end

	// cut a hang short well beyond the expected run
	initial begin
		#80000;
		num_errors++;
		summarize();
	end
endmodule : testbench
